// ---- sram_ctrl.sv ----
// Controller end: makes the link clocks, issues bursts and captures read data on echo clocks
`timescale 1ns/1ps
module sram_ctrl #(
	parameter int AW = sram_link_pkg::ADDR_W,
	parameter int DW = sram_link_pkg::DATA_W,
	parameter int BW = sram_link_pkg::DATA_W / sram_link_pkg::LANE_W,
	parameter int HALF = sram_link_pkg::LINK_HALF_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	sram_link_if.ctrl lk,
	input wire logic loop_disable,
	input wire logic rd_req,
	input wire logic [AW-1:0] rd_addr,
	output logic rd_ready,
	input wire logic wr_req,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data0,
	input wire logic [DW-1:0] wr_data1,
	input wire logic [2*BW-1:0] wr_be_n,
	output logic wr_ready,
	output logic [DW-1:0] rd_data0,
	output logic [DW-1:0] rd_data1,
	output logic rd_valid
);
	localparam int MID = HALF / 2;

	typedef struct packed {
		logic [15:0] cnt;
		logic k;
		logic slot_wr;
		logic loop;
		logic [AW-1:0] addr;
		logic rsel_n;
		logic wsel_n;
		logic [DW-1:0] d;
		logic [BW-1:0] be_n;
		logic w1pend;
		logic [DW-1:0] wd1;
		logic [BW-1:0] wb1;
		logic [1:0][DW-1:0] q_s;
		logic [1:0] v_s;
		logic [2:0] cq_s;
		logic [2:0] cqn_s;
		logic got0;
		logic [DW-1:0] rw0;
		logic [DW-1:0] rd0;
		logic [DW-1:0] rd1;
		logic rv;
	} st_t;

	st_t s_r;
	st_t s_nxt;
	logic launch;
	logic cq_rise;
	logic cqn_rise;

	// Pins change mid-way through each half so they are stable at the device's sampling rise
	assign launch = s_r.cnt == 16'(MID);
	assign wr_ready = launch & ~s_r.k & s_r.slot_wr;
	assign rd_ready = launch & ~s_r.k & ~s_r.slot_wr;
	assign cq_rise = s_r.cq_s[1] & ~s_r.cq_s[2];
	assign cqn_rise = s_r.cqn_s[1] & ~s_r.cqn_s[2];

	always_comb begin
		s_nxt = s_r;
		s_nxt.rv = 1'b0;
		s_nxt.loop = loop_disable;
		if (s_r.cnt == 16'(HALF - 1)) begin
			s_nxt.cnt = '0;
			s_nxt.k = ~s_r.k;
			if (!s_r.k) begin
				s_nxt.slot_wr = ~s_r.slot_wr;
			end
		end else begin
			s_nxt.cnt = s_r.cnt + 16'h0001;
		end
		if (launch && !s_r.k) begin
			s_nxt.rsel_n = 1'b1;
			s_nxt.wsel_n = 1'b1;
			s_nxt.w1pend = 1'b0;
			if (s_r.slot_wr && wr_req) begin
				s_nxt.wsel_n = 1'b0;
				s_nxt.addr = wr_addr;
				s_nxt.d = wr_data0;
				s_nxt.be_n = wr_be_n[BW-1:0];
				s_nxt.w1pend = 1'b1;
				s_nxt.wd1 = wr_data1;
				s_nxt.wb1 = wr_be_n[2*BW-1:BW];
			end else if (!s_r.slot_wr && rd_req) begin
				s_nxt.rsel_n = 1'b0;
				s_nxt.addr = rd_addr;
			end
		end
		if (launch && s_r.k && s_r.w1pend) begin
			s_nxt.d = s_r.wd1;
			s_nxt.be_n = s_r.wb1;
		end
		// Returning data is captured on the echo clock rises, after two stages
		s_nxt.q_s = {s_r.q_s[0], lk.q};
		s_nxt.v_s = {s_r.v_s[0], lk.read_valid_flag};
		s_nxt.cq_s = {s_r.cq_s[1:0], lk.echo_clock_out};
		s_nxt.cqn_s = {s_r.cqn_s[1:0], lk.echo_clock_out_n};
		// Word 0 rides whichever echo edge first shows valid: a fall with the loop on, a rise with it off
		if (cq_rise || cqn_rise) begin
			if (!s_r.v_s[1]) begin
				s_nxt.got0 = 1'b0;
			end else if (!s_r.got0) begin
				s_nxt.got0 = 1'b1;
				s_nxt.rw0 = s_r.q_s[1];
			end else begin
				s_nxt.got0 = 1'b0;
				s_nxt.rd0 = s_r.rw0;
				s_nxt.rd1 = s_r.q_s[1];
				s_nxt.rv = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= '0;
			// The complement echo idles high; a low history would fake an edge after reset
			s_r.cqn_s <= '1;
			s_r.rsel_n <= 1'b1;
			s_r.wsel_n <= 1'b1;
			s_r.be_n <= '1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.k = s_r.k;
	assign lk.k_n = ~s_r.k;
	assign lk.addr = s_r.addr;
	assign lk.rd_sel_n = s_r.rsel_n;
	assign lk.wr_sel_n = s_r.wsel_n;
	assign lk.d = s_r.d;
	assign lk.byte_write_select_n = s_r.be_n;
	assign lk.loop_disable_pin = s_r.loop;
	assign rd_data0 = s_r.rd0;
	assign rd_data1 = s_r.rd1;
	assign rd_valid = s_r.rv;
endmodule

// ---- sram_dev.sv ----
// Memory device end: two-word burst static memory with split read and write ports
// Function
// - Read and write addresses alternate on one bus
// - Each address holds a two-word burst
// - Loop pin high: read data 2.5 cycles
// - Loop pin low: read data one cycle
// - Words move on both clock rises
// - Read and write ports run independently
// - Separate select per port for expansion
// - Read-valid flag marks valid output data
// - Echo clocks travel with read data
// - Inputs captured on input clock rises
// - Read data launched from output registers
// - Accepted writes finish self-timed internally
// - Reads return newest data, pending writes included
// - Link clock up to 450 MHz
// - Only rising edges of clocks used
`timescale 1ns/1ps
module sram_dev #(
	parameter int AW = sram_link_pkg::ADDR_W,
	parameter int DW = sram_link_pkg::DATA_W,
	parameter int BW = sram_link_pkg::DATA_W / sram_link_pkg::LANE_W
) (
	input wire logic clk,
	input wire logic rstn,
	sram_link_if.dev lk,
	output logic read_taken,
	output logic write_done,
	output logic long_latency
);
	localparam int DEPTH = 1 << AW;
	localparam int LW = DW / BW;
	localparam int PD = sram_link_pkg::READ_PIPE_DEPTH;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic rsel_n;
		logic wsel_n;
		logic [DW-1:0] d;
		logic [BW-1:0] be_n;
		logic loop;
	} pins_t;

	typedef struct packed {
		logic [2:0] k_s;
		logic [2:0] kn_s;
		pins_t in1;
		pins_t in2;
		logic slot_wr;
		logic wpend;
		logic [AW-1:0] waddr;
		logic [DW-1:0] wd0;
		logic [BW-1:0] wb0;
		logic wbv;
		logic [AW-1:0] wba;
		logic [1:0][DW-1:0] wbd;
		logic [1:0][BW-1:0] wbb;
		logic [PD-1:0] pv;
		logic [PD-1:0][1:0][DW-1:0] pd;
		logic [DW-1:0] q;
		logic qv;
		logic cq;
		logic rd_tk;
		logic wr_cm;
		logic [DEPTH-1:0][1:0][DW-1:0] mem;
	} st_t;

	st_t s_r;
	st_t s_nxt;

	// Byte lanes with a low select take the new value
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
		input logic [BW-1:0] be_n);
		logic [DW-1:0] r;
		r = old;
		for (int i = 0; i < BW; i++) begin
			if (!be_n[i]) begin
				r[i*LW +: LW] = nw[i*LW +: LW];
			end
		end
		return r;
	endfunction

	logic k_rise;
	logic kn_rise;
	logic lat_long;
	int lat;

	// Each link clock half must last several clk so the sync stages see every level
	// Only rises are used; a falling edge of either clock does nothing
	assign k_rise = s_r.k_s[1] & ~s_r.k_s[2];
	assign kn_rise = s_r.kn_s[1] & ~s_r.kn_s[2];
	assign lat_long = s_r.in2.loop;
	assign lat = lat_long ? sram_link_pkg::LAT_LOOP_ON_HALF : sram_link_pkg::LAT_LOOP_OFF_HALF;

	always_comb begin
		logic [1:0][DW-1:0] rw;
		logic [AW-1:0] ra;
		rw = '0;
		ra = '0;
		s_nxt = s_r;
		s_nxt.rd_tk = 1'b0;
		s_nxt.wr_cm = 1'b0;
		// Every pin input passes two stages before any logic looks at it
		s_nxt.k_s = {s_r.k_s[1:0], lk.k};
		s_nxt.kn_s = {s_r.kn_s[1:0], lk.k_n};
		s_nxt.in1.addr = lk.addr;
		s_nxt.in1.rsel_n = lk.rd_sel_n;
		s_nxt.in1.wsel_n = lk.wr_sel_n;
		s_nxt.in1.d = lk.d;
		s_nxt.in1.be_n = lk.byte_write_select_n;
		s_nxt.in1.loop = lk.loop_disable_pin;
		s_nxt.in2 = s_r.in1;
		ra = s_r.in2.addr;
		// Read port sees the array plus any write still in the buffer
		for (int w = 0; w < 2; w++) begin
			rw[w] = s_r.mem[ra][w];
			if (s_r.wbv && s_r.wba == ra) begin
				rw[w] = merge(rw[w], s_r.wbd[w], s_r.wbb[w]);
			end
		end
		if (k_rise || kn_rise) begin
			// Output stage: word 0 at the latency edge, word 1 on the next rise
			if (s_r.pv[lat-1]) begin
				s_nxt.q = s_r.pd[lat-1][0];
				s_nxt.qv = 1'b1;
			end else if (s_r.pv[lat]) begin
				s_nxt.q = s_r.pd[lat][1];
				s_nxt.qv = 1'b1;
			end else begin
				s_nxt.qv = 1'b0;
			end
			s_nxt.pv = {s_r.pv[PD-2:0], 1'b0};
			s_nxt.pd = {s_r.pd[PD-2:0], {2 * DW{1'b0}}};
		end
		if (k_rise) begin
			s_nxt.cq = 1'b1;
			s_nxt.slot_wr = ~s_r.slot_wr;
			// Buffered write lands on the next true rise, no strobe needed from outside
			if (s_r.wbv) begin
				for (int w = 0; w < 2; w++) begin
					s_nxt.mem[s_r.wba][w] = merge(s_r.mem[s_r.wba][w], s_r.wbd[w], s_r.wbb[w]);
				end
				s_nxt.wbv = 1'b0;
				s_nxt.wr_cm = 1'b1;
			end
			if (!s_r.slot_wr && !s_r.in2.rsel_n) begin
				s_nxt.pv[0] = 1'b1;
				s_nxt.pd[0] = rw;
				s_nxt.rd_tk = 1'b1;
			end
			if (s_r.slot_wr && !s_r.in2.wsel_n) begin
				s_nxt.wpend = 1'b1;
				s_nxt.waddr = s_r.in2.addr;
				s_nxt.wd0 = s_r.in2.d;
				s_nxt.wb0 = s_r.in2.be_n;
			end
		end
		if (kn_rise) begin
			s_nxt.cq = 1'b0;
			// Second word completes the burst; the port does not wait on reads
			if (s_r.wpend) begin
				s_nxt.wpend = 1'b0;
				s_nxt.wbv = 1'b1;
				s_nxt.wba = s_r.waddr;
				s_nxt.wbd = {s_r.in2.d, s_r.wd0};
				s_nxt.wbb = {s_r.in2.be_n, s_r.wb0};
			end
		end
	end

	// Array contents are left alone by reset; control state, pin stages and the output word are cleared
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= s_nxt;
			s_r.k_s <= '0;
			// Idle pin levels, so no false complement rise or select is seen after reset
			s_r.kn_s <= '1;
			s_r.in1 <= '0;
			s_r.in2 <= '0;
			s_r.in1.rsel_n <= 1'b1;
			s_r.in1.wsel_n <= 1'b1;
			s_r.in1.be_n <= '1;
			s_r.in2.rsel_n <= 1'b1;
			s_r.in2.wsel_n <= 1'b1;
			s_r.in2.be_n <= '1;
			s_r.slot_wr <= 1'b0;
			s_r.wpend <= 1'b0;
			s_r.wbv <= 1'b0;
			s_r.pv <= '0;
			s_r.q <= '0;
			s_r.qv <= 1'b0;
			s_r.cq <= 1'b0;
			s_r.rd_tk <= 1'b0;
			s_r.wr_cm <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.q = s_r.q;
	assign lk.read_valid_flag = s_r.qv;
	assign lk.echo_clock_out = s_r.cq;
	assign lk.echo_clock_out_n = ~s_r.cq;
	assign read_taken = s_r.rd_tk;
	assign write_done = s_r.wr_cm;
	assign long_latency = s_r.in2.loop;
endmodule

// ---- sram_link_if.sv ----
// Pin-level link between the burst memory device and its controller
`timescale 1ns/1ps
interface sram_link_if #(
	parameter int AW = sram_link_pkg::ADDR_W,
	parameter int DW = sram_link_pkg::DATA_W,
	parameter int BW = sram_link_pkg::DATA_W / sram_link_pkg::LANE_W
);
	logic k;
	logic k_n;
	logic [AW-1:0] addr;
	logic rd_sel_n;
	logic wr_sel_n;
	logic [DW-1:0] d;
	logic [BW-1:0] byte_write_select_n;
	logic loop_disable_pin;
	logic [DW-1:0] q;
	logic echo_clock_out;
	logic echo_clock_out_n;
	logic read_valid_flag;

	modport dev (
		input k,
		input k_n,
		input addr,
		input rd_sel_n,
		input wr_sel_n,
		input d,
		input byte_write_select_n,
		input loop_disable_pin,
		output q,
		output echo_clock_out,
		output echo_clock_out_n,
		output read_valid_flag
	);

	modport ctrl (
		output k,
		output k_n,
		output addr,
		output rd_sel_n,
		output wr_sel_n,
		output d,
		output byte_write_select_n,
		output loop_disable_pin,
		input q,
		input echo_clock_out,
		input echo_clock_out_n,
		input read_valid_flag
	);
endinterface

// ---- sram_link_pkg.sv ----
// Shared constants for the burst memory link and its controller
package sram_link_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int BURST_LEN = 2;
	// Link clock limits
	localparam int LINK_MAX_MHZ = 450;
	localparam int LINK_DATA_MAX_MHZ = 900;
	// Read latency in half link cycles (one unit per true or complementary rise)
	localparam int LAT_LOOP_ON_HALF = 5;
	localparam int LAT_LOOP_OFF_HALF = 2;
	localparam int READ_PIPE_DEPTH = LAT_LOOP_ON_HALF + 1;
	// Timing of the link clock made by the controller
	localparam int CLK_PERIOD_PS = 5000;
	localparam int LINK_HALF_PS = 40000;
	localparam int LINK_HALF_CYC = (LINK_HALF_PS / CLK_PERIOD_PS) < 1 ? 1 : (LINK_HALF_PS / CLK_PERIOD_PS);
	localparam int SYNC_STAGES = 2;
endpackage

// ---- sram_link_sva.sv ----
// Assertions on the link between the burst memory and its controller
`timescale 1ns/1ps
module sram_link_sva #(
	parameter int HALF = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic k,
	input wire logic k_n,
	input wire logic rd_sel_n,
	input wire logic wr_sel_n,
	input wire logic loop_disable_pin,
	input wire logic echo_clock_out,
	input wire logic echo_clock_out_n,
	input wire logic read_valid_flag
);
	// Pin edge to device output is a few clk of sync delay, so windows are padded
	localparam int LONG_LO = 5 * HALF;
	localparam int LONG_HI = 5 * HALF + 6;
	localparam int SHORT_LO = 2 * HALF;
	localparam int SHORT_HI = 2 * HALF + 6;
	logic k_d_r;
	logic rd_slot_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// First k rise after reset is a read slot
	always_ff @(posedge clk) begin
		k_d_r <= k;
		if (!rstn) begin
			rd_slot_r <= 1'b1;
		end else if (k && !k_d_r) begin
			rd_slot_r <= ~rd_slot_r;
		end
	end

	chk_clock_pair: assert property (k_n == ~k)
		else $error("link clock pair not complementary");
	chk_echo_pair: assert property ((echo_clock_out_n == ~echo_clock_out)
		and ($changed(read_valid_flag) |-> $changed(echo_clock_out)))
		else $error("echo clocks not complementary or not moving with valid");
	chk_echo_rise: assert property ($rose(k) |-> ##[2:4] $rose(echo_clock_out))
		else $error("echo clock did not follow true clock rise");
	chk_echo_fall: assert property ($fell(k) |-> ##[2:4] $fell(echo_clock_out))
		else $error("echo clock did not follow complement rise");
	// Fixed at the default half period of 8 clk
	chk_half_period: assert property ($rose(k) |=> k [*7] ##1 !k)
		else $error("link clock high phase wrong length");
	chk_read_slot: assert property ($rose(k) && !rd_slot_r |-> rd_sel_n)
		else $error("read select low in a write slot");
	chk_write_slot: assert property ($rose(k) && rd_slot_r |-> wr_sel_n)
		else $error("write select low in a read slot");
	chk_long_latency: assert property ($rose(k) && rd_slot_r && !rd_sel_n && loop_disable_pin
		|-> ##[LONG_LO:LONG_HI] $rose(read_valid_flag))
		else $error("long read latency missed");
	chk_short_latency: assert property ($rose(k) && rd_slot_r && !rd_sel_n && !loop_disable_pin
		|-> ##[SHORT_LO:SHORT_HI] $rose(read_valid_flag))
		else $error("short read latency missed");
	chk_valid_burst: assert property ($rose(read_valid_flag) |-> read_valid_flag [*8])
		else $error("valid flag shorter than one word");
endmodule

// ---- test_dual_port_ddr_burst_sram.sv ----
// Bench joining the memory device and its controller over one link
`timescale 1ns/1ps
module test_dual_port_ddr_burst_sram;
	localparam int AW = sram_link_pkg::ADDR_W;
	localparam int DW = sram_link_pkg::DATA_W;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic loop_disable = 1'b1;
	logic rd_req = 1'b0;
	logic [AW-1:0] rd_addr = '0;
	logic wr_req = 1'b0;
	logic [AW-1:0] wr_addr = '0;
	logic [DW-1:0] wr_data0 = '0;
	logic [DW-1:0] wr_data1 = '0;
	logic [3:0] wr_be_n = 4'hF;
	logic rd_ready, wr_ready, rd_valid, long_latency;
	logic read_taken, write_done;
	int wr_calls = 0;
	int rd_calls = 0;
	int wdone_n = 0;
	int rtake_n = 0;
	logic [DW-1:0] rd_data0, rd_data1;
	int mismatches = 0;
	int check_count = 0;
	int seed = 32'hA5FB;
	logic [DW-1:0] m0 [256];
	logic [DW-1:0] m1 [256];
	logic [AW-1:0] used [8];

	sram_link_if lk();
	sram_dev u_sram_dev(.clk(clk), .rstn(rstn), .lk(lk), .read_taken(read_taken), .write_done(write_done),
		.long_latency(long_latency));
	sram_ctrl u_sram_ctrl(.clk(clk), .rstn(rstn), .lk(lk), .loop_disable(loop_disable), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_ready(rd_ready), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data0(wr_data0),
		.wr_data1(wr_data1), .wr_be_n(wr_be_n), .wr_ready(wr_ready), .rd_data0(rd_data0),
		.rd_data1(rd_data1), .rd_valid(rd_valid));
	sram_link_sva u_sva(.clk(clk), .rstn(rstn), .k(lk.k), .k_n(lk.k_n), .rd_sel_n(lk.rd_sel_n),
		.wr_sel_n(lk.wr_sel_n), .loop_disable_pin(lk.loop_disable_pin), .echo_clock_out(lk.echo_clock_out),
		.echo_clock_out_n(lk.echo_clock_out_n), .read_valid_flag(lk.read_valid_flag));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// Pulses are counted mid-cycle, away from the edge that launches them
	always @(negedge clk) begin
		if (write_done === 1'b1) wdone_n++;
		if (read_taken === 1'b1) rtake_n++;
	end

	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw, input logic [1:0] ben);
		merge = old;
		if (!ben[0]) merge[8:0] = nw[8:0];
		if (!ben[1]) merge[17:9] = nw[17:9];
	endfunction

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w0, input logic [DW-1:0] w1, input logic [3:0] be);
		int n;
		@(posedge clk);
		wr_req <= 1'b1;
		wr_addr <= a;
		wr_data0 <= w0;
		wr_data1 <= w1;
		wr_be_n <= be;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (wr_ready !== 1'b1 && n < 200);
		check(DW'(wr_ready), DW'(1'b1));
		wr_calls++;
		@(posedge clk);
		wr_req <= 1'b0;
		m0[a] = merge(m0[a], w0, be[1:0]);
		m1[a] = merge(m1[a], w1, be[3:2]);
	endtask

	task automatic rd(input logic [AW-1:0] a);
		int n;
		logic [DW-1:0] e0, e1;
		e0 = m0[a];
		e1 = m1[a];
		@(posedge clk);
		rd_req <= 1'b1;
		rd_addr <= a;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rd_ready !== 1'b1 && n < 200);
		check(DW'(rd_ready), DW'(1'b1));
		rd_calls++;
		@(posedge clk);
		rd_req <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rd_valid !== 1'b1 && n < 400);
		check(DW'(rd_valid), DW'(1'b1));
		check(rd_data0, e0);
		check(rd_data1, e1);
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Generous bound: the whole sequence needs well under 10000 clk
	initial begin
		#200000;
		mismatches++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Top bits keep the eight addresses distinct; first and last are the corners
		for (int i = 0; i < 8; i++) begin
			used[i] = {3'(i), (i == 0) ? 5'h00 : (i == 7) ? 5'h1F : 5'($random(seed))};
			wr(used[i], DW'($random(seed)), DW'($random(seed)), 4'h0);
			rd(used[i]);
		end
		check(DW'(long_latency), DW'(1'b1));
		$display("Full burst write and read done");
		for (int b = 0; b < 16; b++) begin
			wr(used[b % 8], DW'($random(seed)), DW'($random(seed)), 4'(b));
			rd(used[b % 8]);
		end
		$display("Lane select writes done");
		for (int i = 0; i < 8; i++) begin
			fork
				wr(used[i], DW'($random(seed)), DW'($random(seed)), 4'h0);
				rd(used[(i + 1) % 8]);
			join
		end
		$display("Concurrent ports done");
		@(posedge clk);
		loop_disable <= 1'b0;
		repeat (20) @(posedge clk);
		check(DW'(long_latency), DW'(1'b0));
		for (int i = 0; i < 8; i++) begin
			fork
				wr(used[7 - i], DW'($random(seed)), DW'($random(seed)), 4'(i));
				rd(used[i]);
			join
			rd(used[7 - i]);
		end
		check(DW'(wdone_n), DW'(wr_calls));
		check(DW'(rtake_n), DW'(rd_calls));
		$display("Short latency reads done");
		summarize();
	end
endmodule
